// [pmd_pkg.sv]
// Constants shared by the peripheral map descriptor parser.
`default_nettype none
package pmd_pkg;
  localparam logic [7:0] TAG_PERIPHERAL_MAP = 8'h02;
  localparam logic [7:0] TAG_EXTENDER = 8'hfe;
  localparam logic [7:0] DELIMITER = 8'h00;
  localparam logic [7:0] MODULE_NONE = 8'h00;
  localparam logic [7:0] MODULE_SPECIAL = 8'hfe;
  localparam logic [7:0] MODULE_UNDEFINED = 8'hff;
  localparam int MT_HI = 15;
  localparam int MT_LO = 13;
  localparam int SZ_HI = 12;
  localparam int SZ_LO = 9;
  localparam int MORE_BIT = 8;
  localparam int UNIT_BIT = 7;
  localparam int MULT_HI = 6;
  localparam int MOD_HI = 15;
  localparam int MOD_LO = 8;
  localparam logic [2:0] MT_NONE = 3'h0;
  localparam logic [2:0] MT_RAM = 3'h1;
  localparam logic [2:0] MT_EEPROM = 3'h2;
  localparam logic [2:0] MT_RESERVED = 3'h3;
  localparam logic [2:0] MT_FLASH = 3'h4;
  localparam logic [2:0] MT_ROM = 3'h5;
  localparam logic [2:0] MT_APPENDED = 3'h6;
  localparam logic [2:0] MT_UNDEFINED = 3'h7;
  localparam logic [3:0] SZ_ZERO = 4'h0;
  localparam logic [3:0] SZ_APPENDED = 4'he;
  localparam logic [3:0] SZ_UNDEFINED = 4'hf;
  localparam int SZ_BASE_SHIFT = 6;
  localparam int MEM_UNIT_SMALL_SHIFT = 9;
  localparam int MEM_UNIT_LARGE_SHIFT = 16;
  localparam int PER_UNIT_SMALL_SHIFT = 4;
  localparam int PER_UNIT_LARGE_SHIFT = 11;
  localparam logic [15:0] FIRST_SOURCE_VECTOR = 16'hfff8;
  localparam logic [15:0] VECTOR_STEP = 16'h0002;
  localparam logic [15:0] RESET_VECTOR_WORD = 16'hfffe;
  localparam logic [15:0] SYSTEM_NMI_VECTOR_WORD = 16'hfffc;
  localparam logic [15:0] USER_NMI_VECTOR_WORD = 16'hfffa;
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STATUS = 8'h04;
  localparam logic [7:0] WB_IRQ_STATUS = 8'h08;
  localparam logic [7:0] WB_IRQ_MASK = 8'h0c;
  localparam logic [7:0] WB_START_ADDR = 8'h10;
  localparam logic [7:0] WB_END_ADDR = 8'h14;
  localparam int CTRL_START = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABSENT = 1;
  localparam int IRQ_ERROR = 2;
  localparam int IRQ_MEM = 3;
  localparam int IRQ_PERIPH = 4;
  localparam int IRQ_VECTOR = 5;
  localparam int IRQ_W = 6;
endpackage : pmd_pkg
`default_nettype wire

// [pmd_parser.sv]
// Peripheral map descriptor parser with a Wishbone register port.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pmd_parser #(
  parameter int ADDR_W = 16
) (
  // Clock, reset and enable.
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Descriptor memory read port, data taken in the same cycle as the read strobe.
  output logic o_mem_rd,
  output logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [7:0] i_mem_data,
  // Decoded results.
  output logic o_region_valid,
  output logic [2:0] o_region_type,
  output logic [23:0] o_region_size,
  output logic [23:0] o_region_start,
  output logic o_periph_valid,
  output logic [7:0] o_module_identifier,
  output logic [15:0] o_periph_base,
  output logic o_vector_valid,
  output logic [7:0] o_vector_module,
  output logic [15:0] o_vector_word,
  output logic o_busy,
  output logic o_done,
  output logic o_absent,
  output logic o_error,
  output logic o_irq
);
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001, ST_TAG = 10'h002, ST_LEN = 10'h004, ST_SKIP = 10'h008,
    ST_MEMHI = 10'h010, ST_MEMLO = 10'h020, ST_COUNT = 10'h040,
    ST_PERHI = 10'h080, ST_PERLO = 10'h100, ST_SRC = 10'h200
  } pmd_state_e;

  pmd_state_e state;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] end_addr;
  logic pending;
  logic [1:0] len_left;
  logic is_ext;
  logic is_map;
  logic [15:0] skip_len;
  logic [7:0] hi_byte;
  logic [7:0] per_left;
  logic [15:0] prev_base;
  logic [15:0] next_vector;
  logic [pmd_pkg::IRQ_W-1:0] irq_status;
  logic [pmd_pkg::IRQ_W-1:0] irq_mask;

  wire [7:0] byte_in = i_mem_data;
  wire at_end = ptr >= end_addr;
  wire step = i_ce && pending;
  wire [15:0] word_in = {hi_byte, byte_in};
  wire [2:0] mem_type = word_in[pmd_pkg::MT_HI:pmd_pkg::MT_LO];
  wire [3:0] size_code = word_in[pmd_pkg::SZ_HI:pmd_pkg::SZ_LO];
  wire unit_sel = word_in[pmd_pkg::UNIT_BIT];
  wire [6:0] mult = word_in[pmd_pkg::MULT_HI:0];
  wire type_bad = (mem_type == pmd_pkg::MT_RESERVED) || (mem_type == pmd_pkg::MT_UNDEFINED);
  wire size_bad = size_code == pmd_pkg::SZ_UNDEFINED;
  wire [23:0] size_bytes = (size_code == pmd_pkg::SZ_ZERO || size_code == pmd_pkg::SZ_APPENDED) ?
    24'h000000 : 24'(24'h000001 << (pmd_pkg::SZ_BASE_SHIFT + int'(size_code)));
  wire [23:0] mem_start = unit_sel ? 24'({17'h00000, mult} << pmd_pkg::MEM_UNIT_LARGE_SHIFT) :
    24'({17'h00000, mult} << pmd_pkg::MEM_UNIT_SMALL_SHIFT);
  wire [15:0] per_off = unit_sel ? 16'({9'h000, mult} << pmd_pkg::PER_UNIT_LARGE_SHIFT) :
    16'({9'h000, mult} << pmd_pkg::PER_UNIT_SMALL_SHIFT);
  wire [15:0] per_base = prev_base + per_off;
  wire [2:0] adr_hit_sel = i_wb_adr[4:2];
  wire wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wb_wr = wb_req && i_wb_we && i_wb_sel[0];
  wire start_req = wb_wr && (i_wb_adr == pmd_pkg::WB_CTRL) && i_wb_dat[pmd_pkg::CTRL_START];
  wire [pmd_pkg::IRQ_W-1:0] irq_clear = (wb_wr && i_wb_adr == pmd_pkg::WB_IRQ_STATUS) ?
    i_wb_dat[pmd_pkg::IRQ_W-1:0] : '0;
  wire [pmd_pkg::IRQ_W-1:0] irq_set = {o_vector_valid, o_periph_valid, o_region_valid,
    o_error, o_absent, o_done};
  wire [31:0] rd_status = {28'h0000000, o_error, o_absent, o_done, o_busy};
  wire [31:0] rd_mux = (i_wb_adr == pmd_pkg::WB_STATUS) ? rd_status :
    (i_wb_adr == pmd_pkg::WB_IRQ_STATUS) ? {26'h0000000, irq_status} :
    (i_wb_adr == pmd_pkg::WB_IRQ_MASK) ? {26'h0000000, irq_mask} :
    (i_wb_adr == pmd_pkg::WB_START_ADDR) ? 32'(start_addr) :
    (i_wb_adr == pmd_pkg::WB_END_ADDR) ? 32'(end_addr) : 32'h00000000;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      start_addr <= '0;
      end_addr <= '0;
      irq_mask <= '0;
      irq_status <= '0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_mux : 32'h00000000;
      if (wb_wr && i_wb_adr == pmd_pkg::WB_START_ADDR) start_addr <= i_wb_dat[ADDR_W-1:0];
      if (wb_wr && i_wb_adr == pmd_pkg::WB_END_ADDR) end_addr <= i_wb_dat[ADDR_W-1:0];
      if (wb_wr && i_wb_adr == pmd_pkg::WB_IRQ_MASK) irq_mask <= i_wb_dat[pmd_pkg::IRQ_W-1:0];
      irq_status <= (irq_status & ~irq_clear) | irq_set;
      o_irq <= |(((irq_status & ~irq_clear) | irq_set) & irq_mask);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      ptr <= '0;
      pending <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_addr <= '0;
      len_left <= 2'h0;
      is_ext <= 1'b0;
      is_map <= 1'b0;
      skip_len <= 16'h0000;
      hi_byte <= 8'h00;
      per_left <= 8'h00;
      prev_base <= 16'h0000;
      next_vector <= pmd_pkg::FIRST_SOURCE_VECTOR;
      o_region_valid <= 1'b0;
      o_region_type <= 3'h0;
      o_region_size <= 24'h000000;
      o_region_start <= 24'h000000;
      o_periph_valid <= 1'b0;
      o_module_identifier <= 8'h00;
      o_periph_base <= 16'h0000;
      o_vector_valid <= 1'b0;
      o_vector_module <= 8'h00;
      o_vector_word <= 16'h0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_absent <= 1'b0;
      o_error <= 1'b0;
    end else if (i_ce) begin
      o_region_valid <= 1'b0;
      o_periph_valid <= 1'b0;
      o_vector_valid <= 1'b0;
      o_done <= 1'b0;
      o_absent <= 1'b0;
      o_error <= 1'b0;
      o_mem_rd <= 1'b0;
      pending <= 1'b0;
      if (state == ST_IDLE) begin
        if (start_req) begin
          state <= ST_TAG;
          ptr <= start_addr;
          o_busy <= 1'b1;
          prev_base <= 16'h0000;
          next_vector <= pmd_pkg::FIRST_SOURCE_VECTOR;
          o_mem_rd <= 1'b1;
          o_mem_addr <= start_addr;
          pending <= 1'b1;
        end
      end else if (state == ST_SKIP) begin
        ptr <= ptr + ADDR_W'(skip_len);
        skip_len <= 16'h0000;
        state <= ST_TAG;
      end else if (!pending && at_end) begin
        state <= ST_IDLE;
        o_busy <= 1'b0;
        if (state == ST_TAG) o_absent <= 1'b1;
        else o_error <= 1'b1;
      end else if (!pending) begin
        o_mem_rd <= 1'b1;
        o_mem_addr <= ptr;
        pending <= 1'b1;
      end else if (step) begin
        ptr <= ptr + 1'b1;
        unique case (state)
          ST_TAG: begin
            state <= ST_LEN;
            is_map <= byte_in == pmd_pkg::TAG_PERIPHERAL_MAP;
            is_ext <= byte_in == pmd_pkg::TAG_EXTENDER;
            len_left <= (byte_in == pmd_pkg::TAG_EXTENDER) ? 2'h3 : 2'h1;
            skip_len <= 16'h0000;
          end
          ST_LEN: begin
            len_left <= len_left - 1'b1;
            if (!(is_ext && len_left == 2'h3)) skip_len <= {skip_len[7:0], byte_in};
            if (len_left == 2'h1) state <= is_map ? ST_MEMHI : ST_SKIP;
          end
          ST_MEMHI: begin
            hi_byte <= byte_in;
            if (byte_in == pmd_pkg::DELIMITER) state <= ST_COUNT;
            else state <= ST_MEMLO;
          end
          ST_MEMLO: begin
            if (type_bad || size_bad) begin
              state <= ST_IDLE;
              o_busy <= 1'b0;
              o_error <= 1'b1;
            end else begin
              state <= ST_MEMHI;
              o_region_valid <= 1'b1;
              o_region_type <= mem_type;
              o_region_size <= size_bytes;
              o_region_start <= mem_start;
            end
          end
          ST_COUNT: begin
            per_left <= byte_in;
            state <= (byte_in == 8'h00) ? ST_SRC : ST_PERHI;
          end
          ST_PERHI: begin
            hi_byte <= byte_in;
            state <= ST_PERLO;
          end
          ST_PERLO: begin
            o_periph_valid <= 1'b1;
            o_module_identifier <= word_in[pmd_pkg::MOD_HI:pmd_pkg::MOD_LO];
            o_periph_base <= per_base;
            prev_base <= per_base;
            per_left <= per_left - 1'b1;
            state <= (per_left == 8'h01) ? ST_SRC : ST_PERHI;
          end
          ST_SRC: begin
            if (byte_in == pmd_pkg::DELIMITER) begin
              state <= ST_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
            end else begin
              o_vector_valid <= 1'b1;
              o_vector_module <= byte_in;
              o_vector_word <= next_vector;
              next_vector <= next_vector - pmd_pkg::VECTOR_STEP;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  chk_vector_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_vector_valid |-> next_vector == o_vector_word - pmd_pkg::VECTOR_STEP)
    else $error("vector step broken");
  chk_first_vector: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (start_req && state == ST_IDLE) |=> next_vector == pmd_pkg::FIRST_SOURCE_VECTOR)
    else $error("first vector not 0fff8h");
  chk_done_from_delim: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done |-> $past(state) == ST_SRC && $past(byte_in) == pmd_pkg::DELIMITER)
    else $error("done without delimiter");
  chk_tag_match: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (step && state == ST_TAG && byte_in == pmd_pkg::TAG_PERIPHERAL_MAP) |=> state == ST_LEN && is_map)
    else $error("tag not accepted");
  chk_absent_clean: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_absent |-> !o_error && !o_busy)
    else $error("absent with error");
  chk_bad_type: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (step && state == ST_MEMLO && type_bad) |=> o_error && !o_region_valid)
    else $error("bad type not flagged");
  chk_base_sum: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (step && state == ST_PERLO) |=> o_periph_base == $past(prev_base) + $past(per_off))
    else $error("base sum wrong");
  chk_mem_start: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (step && state == ST_MEMLO && !type_bad && !size_bad && !unit_sel)
    |=> o_region_start == 24'($past(mult)) * 24'h000200)
    else $error("region start wrong");
  chk_delim_mem: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (step && state == ST_MEMHI && byte_in == pmd_pkg::DELIMITER) |=> state == ST_COUNT)
    else $error("delimiter missed");
  chk_irq_level: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce ##1 (|(irq_status & irq_mask)) |-> o_irq)
    else $error("irq not raised");
  cov_done: cover property (@(posedge i_core_clk) disable iff (i_rst) o_done);
  cov_absent: cover property (@(posedge i_core_clk) disable iff (i_rst) o_absent);
  cov_vector: cover property (@(posedge i_core_clk) disable iff (i_rst) o_vector_valid);
endmodule : pmd_parser
`default_nettype wire

// [pmd_mem_model.sv]
// Byte-wide descriptor memory that answers the parser's read strobe.
`timescale 1ns/100ps
`default_nettype none
module pmd_mem_model (
  // Clock.
  input wire logic i_core_clk,
  // Read port.
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  output logic [7:0] o_mem_data
);
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h5a;
  logic hold = 1'b0;
  // Data stands for the strobe cycle and the next one, then shows the inverse.
  always @(posedge i_core_clk) begin
    hold <= i_mem_rd;
    if (i_mem_rd) begin
      last <= mem[i_mem_addr[7:0]];
    end
  end
  assign o_mem_data = i_mem_rd ? mem[i_mem_addr[7:0]] : (hold ? last : ~last);
endmodule : pmd_mem_model
`default_nettype wire

// [pmd_parser_tb.sv]
// Self-checking bench for the peripheral map descriptor parser.
`timescale 1ns/100ps
`default_nettype none
module pmd_parser_tb;
  logic clk, rst, cyc, stb, we, ack, rd, rvalid, pvalid, vvalid, busy, done, absent, error, irq;
  logic [7:0] adr, mdata, mod_id, vec_mod;
  logic [31:0] wdat, odat, rdat;
  logic [3:0] sel;
  logic [15:0] maddr, pbase, vword;
  logic [2:0] rtype;
  logic [23:0] rsize, rstart;
  int err_total, compares, cycles, ends;
  logic [55:0] regions[$], exp_reg[3];
  logic [23:0] periphs[$], vectors[$], exp_per[4];
  logic [7:0] img[37] = '{8'h11, 8'h02, 8'haa, 8'hbb, 8'hfe, 8'h05, 8'h00, 8'h01, 8'hcc,
    8'h02, 8'h15, 8'h9b, 8'h2e, 8'ha1, 8'h83, 8'h30, 8'h0e, 8'h00, 8'h04, 8'h02, 8'h10,
    8'h51, 8'h0a, 8'h82, 8'h84, 8'hff, 8'h04, 8'h81, 8'h51, 8'h82, 8'h81, 8'h00,
    8'h02, 8'h03, 8'h60, 8'h00, 8'h00};
  pmd_parser dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(odat),
    .o_wb_ack(ack), .o_mem_rd(rd), .o_mem_addr(maddr), .i_mem_data(mdata),
    .o_region_valid(rvalid), .o_region_type(rtype), .o_region_size(rsize),
    .o_region_start(rstart), .o_periph_valid(pvalid), .o_module_identifier(mod_id),
    .o_periph_base(pbase), .o_vector_valid(vvalid), .o_vector_module(vec_mod),
    .o_vector_word(vword), .o_busy(busy), .o_done(done), .o_absent(absent), .o_error(error),
    .o_irq(irq));
  pmd_mem_model mem_model (.i_core_clk(clk), .i_mem_rd(rd), .i_mem_addr(maddr),
    .o_mem_data(mdata));
  function automatic logic [23:0] szb(input logic [3:0] c);
    return (c == 4'h0) ? 24'h000000 : (24'h000080 << (c - 4'h1));
  endfunction : szb
  task automatic finish_test();
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [55:0] got, input logic [55:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // One classic Wishbone cycle; read data is kept in rdat.
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check(ack === 1'b1, 1, "bus answer");
    rdat = odat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_xfer
  task automatic run(input logic [7:0] s, input logic [7:0] e);
    int base;
    regions.delete();
    periphs.delete();
    vectors.delete();
    wb_xfer(1'b1, pmd_pkg::WB_START_ADDR, {24'h000000, s});
    wb_xfer(1'b1, pmd_pkg::WB_END_ADDR, {24'h000000, e});
    base = ends;
    wb_xfer(1'b1, pmd_pkg::WB_CTRL, 32'h00000001);
    for (int i = 0; i < 3000 && ends == base; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    wb_xfer(1'b0, pmd_pkg::WB_IRQ_STATUS, 32'h00000000);
  endtask : run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rvalid === 1'b1) regions.push_back({5'h00, rtype, rsize, rstart});
    if (pvalid === 1'b1) periphs.push_back({mod_id, pbase});
    if (vvalid === 1'b1) vectors.push_back({vec_mod, vword});
    if ((done | absent | error) === 1'b1) ends <= ends + 1;
    if (cycles == 30000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {rst, cyc, stb, we, adr, wdat, sel} = {1'b1, 3'h0, 8'h00, 32'h0, 4'hf};
    {err_total, compares, cycles, ends} = 0;
    for (int i = 0; i < 256; i++) mem_model.mem[i] = 8'hff;
    for (int i = 0; i < 32; i++) mem_model.mem[i] = img[i];
    for (int i = 0; i < 5; i++) mem_model.mem[8'h40 + i] = img[32 + i];
    exp_reg[0] = {5'h00, 3'h4, szb(4'hd), 24'h00002e * 24'h000200};
    exp_reg[1] = {5'h00, 3'h5, szb(4'h0), 24'h000003 * 24'h010000};
    exp_reg[2] = {5'h00, 3'h1, szb(4'h8), 24'h00000e * 24'h000200};
    exp_per[0] = {8'h02, 16'h0010 * 16'h0010};
    exp_per[1] = {8'h51, exp_per[0][15:0] + 16'h000a * 16'h0010};
    exp_per[2] = {8'h82, exp_per[1][15:0] + 16'h0004 * 16'h0800};
    exp_per[3] = {8'hff, exp_per[2][15:0] + 16'h0004 * 16'h0010};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb_xfer(1'b0, 8'h20, 32'h00000000);
    check(rdat, 32'h0, "unmapped read");
    wb_xfer(1'b0, pmd_pkg::WB_IRQ_MASK, 32'h00000000);
    check(rdat, 32'h0, "mask reset");
    wb_xfer(1'b1, pmd_pkg::WB_IRQ_MASK, 32'h00000001);
    // Two foreign records are skipped before the map record is parsed.
    run(8'h00, 8'h20);
    check(rdat, 32'h39, "status after parse");
    check(irq, 1'b1, "irq on done");
    check(regions.size(), 3, "region count");
    for (int i = 0; i < 3; i++) check(regions[i], exp_reg[i], "region");
    check(periphs.size(), 4, "periph count");
    for (int i = 0; i < 4; i++) check(periphs[i], exp_per[i], "periph");
    check(vectors.size(), 4, "vector count");
    for (int i = 0; i < 4; i++) check(vectors[i], {img[27 + i], 16'hfff8 - 16'(2 * i)}, "vector");
    wb_xfer(1'b1, pmd_pkg::WB_IRQ_STATUS, 32'h0000003f);
    wb_xfer(1'b0, pmd_pkg::WB_IRQ_STATUS, 32'h00000000);
    check(rdat, 32'h0, "status cleared");
    check(irq, 1'b0, "irq cleared");
    // Area ends before any map record.
    run(8'h00, 8'h09);
    check(rdat, 32'h02, "absent status");
    check(irq, 1'b0, "absent masked");
    wb_xfer(1'b1, pmd_pkg::WB_IRQ_STATUS, 32'h0000003f);
    // Reserved memory type.
    run(8'h40, 8'h50);
    check(rdat, 32'h04, "reserved type");
    wb_xfer(1'b1, pmd_pkg::WB_IRQ_STATUS, 32'h0000003f);
    // Area ends inside the interrupt list.
    run(8'h09, 8'h1c);
    check(rdat[2:0], 3'h4, "truncated record");
    finish_test();
  end
endmodule : pmd_parser_tb
`default_nettype wire
